// File: core/conv_seq_map.vh
`ifndef CONV_SEQ_MAP_VH
`define CONV_SEQ_MAP_VH

// ****************************************
// Register pointers
// ****************************************
`define PTR_CONFIG_RD 8'h03
`define PTR_CONFIG_WR 8'h09
`define PTR_INTERVAL_RD 8'h04
`define PTR_INTERVAL_WR 8'h0a
`define PTR_SINGLE_SHOT 8'h0f
`define PTR_REMOTE_OFFSET 8'h11
`define PTR_CHANNEL_GATE 8'h16
`define PTR_FAULT_REPEAT 8'h22
`define PTR_IDEALITY_TRIM 8'h23
`define PTR_MAKER_CODE 8'hfe

// ****************************************
// Fields and reset values
// ****************************************
`define CFG_SHUTDOWN_BIT 6
`define GATE_LOCAL_BIT 0
`define GATE_REMOTE_BIT 1
`define INTERVAL_RST 8'h08
`define INTERVAL_MAX 8'h09
`define GATE_RST 2'h3
`define FAULT_REPEAT_RST 4'h1
`define TRIM_RST 8'h00
`define OFFSET_RST 8'h00
`define READ_ZERO 8'h00

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 250
`define CONV_TIME_US 15000
`define MIN_PERIOD_US 31250
`define CONV_CYC_DFLT (`CONV_TIME_US * `CLK_MHZ)
`define MIN_PERIOD_CYC_DFLT (`MIN_PERIOD_US * `CLK_MHZ)

// ****************************************
// Correction constants
// ****************************************
`define ETA_BASE 2088
`define KELVIN_SIXTEENTHS 4370
`define FRAC_BITS 4

`endif

// File: core/result_correct.v
`timescale 1ns/1ps
`default_nettype none
`include "conv_seq_map.vh"

module result_correct #(
  parameter W = 12
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire load_i,
  input wire remote_i,
  input wire [W-1:0] raw_i,
  input wire [7:0] trim_i,
  input wire [7:0] offset_i,
  output reg [W-1:0] result_o,
  output reg remote_o,
  output reg valid_o
);

  // ****************************************
  // Ideality and offset correction
  // ****************************************
  // Scaling acts on absolute temperature, so the raw code is moved to kelvin first
  localparam signed [31:0] MAXV = (1 <<< (W - 1)) - 1;
  localparam signed [31:0] MINV = -(1 <<< (W - 1));
  wire signed [31:0] kelvin = $signed(raw_i) + `KELVIN_SIXTEENTHS;
  wire signed [31:0] scale = `ETA_BASE + $signed(trim_i);
  wire signed [31:0] scaled = (kelvin * scale) / `ETA_BASE - `KELVIN_SIXTEENTHS;
  wire signed [31:0] shifted = scaled + ($signed(offset_i) <<< `FRAC_BITS);
  reg signed [31:0] remote_val;
  always @* begin
    if (shifted > MAXV) begin
      remote_val = MAXV;
    end else if (shifted < MINV) begin
      remote_val = MINV;
    end else begin
      remote_val = shifted;
    end
  end

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      result_o <= {W{1'b0}};
      remote_o <= 1'b0;
      valid_o <= 1'b0;
    end else begin
      valid_o <= load_i;
      if (load_i) begin
        remote_o <= remote_i;
        result_o <= remote_i ? remote_val[W-1:0] : raw_i;
      end
    end
  end

endmodule // result_correct
`default_nettype wire

// File: core/conversion_sequencing_and_correction.v
`timescale 1ns/1ps
`default_nettype none
`include "conv_seq_map.vh"

module conversion_sequencing_and_correction #(
  parameter W = 12,
  parameter [31:0] CONV_CYC = `CONV_CYC_DFLT,
  parameter [31:0] MIN_PERIOD_CYC = `MIN_PERIOD_CYC_DFLT,
  parameter [7:0] MAKER_CODE = 8'ha3 // Arbitrary value
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire [7:0] ptr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  input wire [W-1:0] adc_data_i,
  output reg adc_start_o,
  output reg adc_remote_o,
  output wire busy_o,
  input wire [W-1:0] local_high_lim_i,
  input wire [W-1:0] local_low_lim_i,
  input wire [W-1:0] remote_high_lim_i,
  input wire [W-1:0] remote_low_lim_i,
  input wire flags_clear_i,
  output reg [W-1:0] local_result_o,
  output reg [W-1:0] remote_result_o,
  output reg result_valid_o,
  output wire local_over_flag_o,
  output wire local_under_flag_o,
  output wire remote_over_flag_o,
  output wire remote_under_flag_o,
  output wire alarm_o
);

  // ****************************************
  // States
  // ****************************************
  localparam [1:0] ST_HALT = 2'd0;
  localparam [1:0] ST_WAIT = 2'd1;
  localparam [1:0] ST_LOCAL = 2'd2;
  localparam [1:0] ST_REMOTE = 2'd3;

  // ****************************************
  // Functions
  // ****************************************
  function [31:0] period_of;
    input [7:0] code;
    reg [3:0] sh;
    begin
      sh = (code > `INTERVAL_MAX) ? 4'd0 : (4'd9 - code[3:0]);
      period_of = MIN_PERIOD_CYC << sh;
    end
  endfunction

  function [2:0] needed_of;
    input [3:0] code;
    begin
      case (code)
        4'h3: needed_of = 3'd2;
        4'h7: needed_of = 3'd3;
        4'hf: needed_of = 3'd4;
        default: needed_of = 3'd1;
      endcase
    end
  endfunction

  function [2:0] bump;
    input [2:0] cnt;
    input fault;
    input [2:0] need;
    begin
      if (!fault) begin
        bump = 3'd0;
      end else if (cnt < need) begin
        bump = cnt + 3'd1;
      end else begin
        bump = cnt;
      end
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg shutdown_ctl_reg;
  reg [7:0] interval_reg;
  reg [1:0] gate_reg;
  reg [3:0] fault_repeat_reg;
  reg [7:0] trim_reg;
  reg [7:0] offset_reg;

  wire local_channel_on = gate_reg[`GATE_LOCAL_BIT];
  wire remote_channel_on = gate_reg[`GATE_REMOTE_BIT];

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      shutdown_ctl_reg <= 1'b0;
      interval_reg <= `INTERVAL_RST;
      gate_reg <= `GATE_RST;
      fault_repeat_reg <= `FAULT_REPEAT_RST;
      trim_reg <= `TRIM_RST;
      offset_reg <= `OFFSET_RST;
    end else if (reg_wr_i) begin
      // Single-shot pointer has no storage here: its data byte is dropped
      case (ptr_i)
        `PTR_CONFIG_WR: shutdown_ctl_reg <= wdata_i[`CFG_SHUTDOWN_BIT];
        `PTR_INTERVAL_WR: interval_reg <= wdata_i;
        `PTR_CHANNEL_GATE: gate_reg <= wdata_i[1:0];
        `PTR_FAULT_REPEAT: fault_repeat_reg <= wdata_i[3:0];
        `PTR_IDEALITY_TRIM: trim_reg <= wdata_i;
        `PTR_REMOTE_OFFSET: offset_reg <= wdata_i;
        default: ;
      endcase
    end
  end

  // Read data registered, valid the cycle after the read strobe
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      rdata_o <= `READ_ZERO;
    end else if (reg_rd_i) begin
      case (ptr_i)
        `PTR_CONFIG_RD: rdata_o <= {1'b0, shutdown_ctl_reg, 6'h00};
        `PTR_INTERVAL_RD: rdata_o <= interval_reg;
        `PTR_CHANNEL_GATE: rdata_o <= {6'h00, gate_reg};
        `PTR_FAULT_REPEAT: rdata_o <= {4'h0, fault_repeat_reg};
        `PTR_IDEALITY_TRIM: rdata_o <= trim_reg;
        `PTR_REMOTE_OFFSET: rdata_o <= offset_reg;
        `PTR_MAKER_CODE: rdata_o <= MAKER_CODE;
        default: rdata_o <= `READ_ZERO;
      endcase
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [31:0] period_cnt_reg;
  reg [31:0] conv_cnt_reg;

  wire idle = (state_reg == ST_HALT) || (state_reg == ST_WAIT);
  assign busy_o = !idle;

  // Single shot counts only when fully halted; in continuous mode it is ignored
  wire one_shot = reg_wr_i && (ptr_i == `PTR_SINGLE_SHOT) && shutdown_ctl_reg
                  && (state_reg == ST_HALT);
  wire period_up = (period_cnt_reg == 32'd0);
  wire conv_end = (conv_cnt_reg == 32'd0);
  wire cont_start = !shutdown_ctl_reg && period_up && idle;
  wire cycle_start = cont_start || one_shot;
  // Where the cycle goes once all enabled channels are done
  wire [1:0] after_cycle = shutdown_ctl_reg ? ST_HALT : ST_WAIT;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_HALT, ST_WAIT: begin
        if (cycle_start) begin
          if (local_channel_on) begin
            state_next = ST_LOCAL;
          end else if (remote_channel_on) begin
            state_next = ST_REMOTE;
          end else begin
            state_next = after_cycle;
          end
        end else if (state_reg == ST_WAIT && shutdown_ctl_reg) begin
          state_next = ST_HALT;
        end else if (state_reg == ST_HALT && !shutdown_ctl_reg) begin
          state_next = ST_WAIT;
        end
      end
      ST_LOCAL: begin
        if (conv_end) begin
          state_next = remote_channel_on ? ST_REMOTE : after_cycle;
        end
      end
      ST_REMOTE: begin
        if (conv_end) begin
          state_next = after_cycle;
        end
      end
      default: state_next = ST_HALT;
    endcase
  end

  wire entering_conv = (state_next == ST_LOCAL || state_next == ST_REMOTE)
                       && (state_next != state_reg);

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg <= ST_WAIT;
      period_cnt_reg <= 32'd0;
      conv_cnt_reg <= 32'd0;
      adc_start_o <= 1'b0;
      adc_remote_o <= 1'b0;
    end else begin
      state_reg <= state_next;
      adc_start_o <= entering_conv;
      // Period runs start to start, so idle time absorbs the fixed conversion time
      if (cont_start) begin
        period_cnt_reg <= period_of(interval_reg) - 32'd1;
      end else if (!period_up) begin
        period_cnt_reg <= period_cnt_reg - 32'd1;
      end
      if (entering_conv) begin
        conv_cnt_reg <= CONV_CYC - 32'd1;
        adc_remote_o <= (state_next == ST_REMOTE);
      end else if (!conv_end) begin
        conv_cnt_reg <= conv_cnt_reg - 32'd1;
      end
    end
  end

  // ****************************************
  // Correction and results
  // ****************************************
  wire corr_load = (state_reg == ST_LOCAL || state_reg == ST_REMOTE) && conv_end;
  wire [W-1:0] corr_result;
  wire corr_remote;
  wire corr_valid;

  result_correct #(
    .W(W)
  ) u_correct (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .load_i(corr_load),
    .remote_i(state_reg == ST_REMOTE),
    .raw_i(adc_data_i),
    .trim_i(trim_reg),
    .offset_i(offset_reg),
    .result_o(corr_result),
    .remote_o(corr_remote),
    .valid_o(corr_valid)
  );

  // ****************************************
  // Limit comparison and fault counting
  // ****************************************
  reg [2:0] l_over_cnt_reg;
  reg [2:0] l_under_cnt_reg;
  reg [2:0] r_over_cnt_reg;
  reg [2:0] r_under_cnt_reg;
  reg [3:0] flag_reg;

  wire [2:0] need = needed_of(fault_repeat_reg);
  wire above_l = $signed(corr_result) > $signed(local_high_lim_i);
  wire below_l = $signed(corr_result) < $signed(local_low_lim_i);
  wire above_r = $signed(corr_result) > $signed(remote_high_lim_i);
  wire below_r = $signed(corr_result) < $signed(remote_low_lim_i);
  wire [2:0] l_over_nx = bump(l_over_cnt_reg, above_l, need);
  wire [2:0] l_under_nx = bump(l_under_cnt_reg, below_l, need);
  wire [2:0] r_over_nx = bump(r_over_cnt_reg, above_r, need);
  wire [2:0] r_under_nx = bump(r_under_cnt_reg, below_r, need);
  wire lv = corr_valid && !corr_remote;
  wire rv = corr_valid && corr_remote;
  // Set wins over the clear from the status read
  wire [3:0] flag_set = {lv && l_over_nx >= need, lv && l_under_nx >= need,
                         rv && r_over_nx >= need, rv && r_under_nx >= need};
  wire [3:0] flag_hold = {l_over_cnt_reg != 3'd0, l_under_cnt_reg != 3'd0,
                          r_over_cnt_reg != 3'd0, r_under_cnt_reg != 3'd0};

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      l_over_cnt_reg <= 3'd0;
      l_under_cnt_reg <= 3'd0;
      r_over_cnt_reg <= 3'd0;
      r_under_cnt_reg <= 3'd0;
      flag_reg <= 4'h0;
      local_result_o <= {W{1'b0}};
      remote_result_o <= {W{1'b0}};
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= corr_valid;
      if (lv) begin
        local_result_o <= corr_result;
        l_over_cnt_reg <= l_over_nx;
        l_under_cnt_reg <= l_under_nx;
      end
      if (rv) begin
        remote_result_o <= corr_result;
        r_over_cnt_reg <= r_over_nx;
        r_under_cnt_reg <= r_under_nx;
      end
      if (flags_clear_i) begin
        flag_reg <= (flag_reg & flag_hold) | flag_set;
      end else begin
        flag_reg <= flag_reg | flag_set;
      end
    end
  end

  assign local_over_flag_o = flag_reg[3];
  assign local_under_flag_o = flag_reg[2];
  assign remote_over_flag_o = flag_reg[1];
  assign remote_under_flag_o = flag_reg[0];
  assign alarm_o = |flag_reg;

endmodule // conversion_sequencing_and_correction
`default_nettype wire

// File: testbench/csc_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module csc_checker #(
  parameter [31:0] CONV_CYC = 32'd20,
  parameter [7:0] MAKER_CODE = 8'ha3
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] ptr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic adc_start_o,
  input wire logic busy_o,
  input wire logic result_valid_o,
  input wire logic local_over_flag_o,
  input wire logic local_under_flag_o,
  input wire logic remote_over_flag_o,
  input wire logic remote_under_flag_o,
  input wire logic alarm_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // Cycles since the last conversion start; first start has no predecessor
  logic [31:0] gap_reg;
  logic seen_reg;
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      gap_reg <= 32'h0;
      seen_reg <= 1'b0;
    end else if (adc_start_o) begin
      gap_reg <= 32'h1;
      seen_reg <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 32'h1;
    end
  end
  a_rdata_hold: assert property (!reg_rd_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  a_maker_read: assert property (reg_rd_i && ptr_i == 8'hfe |=> rdata_o == MAKER_CODE)
    else $error("maker code read wrong");
  a_start_busy: assert property (adc_start_o |-> busy_o)
    else $error("start without busy");
  a_start_pulse: assert property (adc_start_o |=> !adc_start_o)
    else $error("start longer than one cycle");
  a_busy_min: assert property ($rose(busy_o) |-> busy_o [*8])
    else $error("conversion cut short");
  a_conv_gap: assert property (adc_start_o && seen_reg |-> gap_reg >= CONV_CYC)
    else $error("channel conversions overlap");
  a_valid_late: assert property (result_valid_o |-> $past(busy_o, 2))
    else $error("result without conversion");
  a_flag_on_valid: assert property ($rose(local_over_flag_o) |-> result_valid_o)
    else $error("flag set without result");
  a_alarm_or: assert property (alarm_o == (local_over_flag_o | local_under_flag_o
    | remote_over_flag_o | remote_under_flag_o))
    else $error("alarm differs from flags");
endmodule // csc_checker
bind conversion_sequencing_and_correction csc_checker #(.CONV_CYC(CONV_CYC), .MAKER_CODE(MAKER_CODE)) csc_checker_i (
  .sys_clk_i, .srst_i, .ptr_i, .reg_rd_i, .rdata_o, .adc_start_o, .busy_o, .result_valid_o,
  .local_over_flag_o, .local_under_flag_o, .remote_over_flag_o, .remote_under_flag_o, .alarm_o);
`default_nettype wire

// File: testbench/adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic remote_i,
  input wire logic busy_i,
  input wire logic [11:0] local_val_i,
  input wire logic [11:0] remote_val_i,
  output logic [11:0] data_o
);
  logic [11:0] hold_reg = 12'h5a5;
  // Outside a conversion the value toggles so a stale sample cannot pass
  always @(posedge clk_i) begin
    if (start_i)
      hold_reg <= remote_i ? remote_val_i : local_val_i;
    else if (!busy_i)
      hold_reg <= ~hold_reg;
  end
  assign data_o = hold_reg;
endmodule // adc_model
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0, flags_clear_i = 0;
  logic [7:0] ptr_i = 8'h00, wdata_i = 8'h00;
  logic [11:0] local_high_lim_i = 12'h064, local_low_lim_i = 12'hf00;
  logic [11:0] remote_high_lim_i = 12'h7ff, remote_low_lim_i = 12'hf00;
  logic [11:0] lv = 12'h010, rv = 12'h000;
  wire [7:0] rdata_o;
  wire [11:0] adc_data_i, local_result_o, remote_result_o;
  wire adc_start_o, adc_remote_o, busy_o, result_valid_o, alarm_o;
  wire local_over_flag_o, local_under_flag_o, remote_over_flag_o, remote_under_flag_o;
  int n_fail = 0, checks = 0, cyc = 0, ns = 0, t, s, n;
  conversion_sequencing_and_correction #(.CONV_CYC(20), .MIN_PERIOD_CYC(64))
    conversion_sequencing_and_correction_i (.sys_clk_i, .srst_i, .ptr_i, .reg_wr_i, .reg_rd_i,
    .wdata_i, .rdata_o, .adc_data_i, .adc_start_o, .adc_remote_o, .busy_o, .local_high_lim_i,
    .local_low_lim_i, .remote_high_lim_i, .remote_low_lim_i, .flags_clear_i, .local_result_o,
    .remote_result_o, .result_valid_o, .local_over_flag_o, .local_under_flag_o,
    .remote_over_flag_o, .remote_under_flag_o, .alarm_o);
  adc_model adc_model_i (.clk_i(sys_clk_i), .start_i(adc_start_o), .remote_i(adc_remote_o),
    .busy_i(busy_o), .local_val_i(lv), .remote_val_i(rv), .data_o(adc_data_i));
  always #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (adc_start_o === 1'b1)
      ns++;
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task chk(input logic [11:0] g, input logic [11:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] p, input logic [7:0] d);
    @(posedge sys_clk_i);
    ptr_i <= p;
    wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] p, input logic [7:0] e);
    @(posedge sys_clk_i);
    ptr_i <= p;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge sys_clk_i);
    #1 chk({4'h0, rdata_o}, {4'h0, e});
  endtask
  // Waits for a local start; sampling after the edge keeps counters settled
  task wl;
    for (int i = 0; i < 3000; i++) begin
      @(posedge sys_clk_i);
      if (adc_start_o === 1'b1 && adc_remote_o === 1'b0)
        break;
    end
    #1;
  endtask
  task bl;
    n = 1;
    while (busy_o === 1'b1 && n < 500) begin
      n++;
      @(posedge sys_clk_i);
      #1;
    end
  endtask
  task idle(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task wrap_up;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (5) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd(8'h04, 8'h08);
    rd(8'h16, 8'h03);
    rd(8'h22, 8'h01);
    rd(8'h23, 8'h00);
    rd(8'hfe, 8'ha3);
    rd(8'h0f, 8'h00);
    rd(8'h05, 8'h00);
    wr(8'h0a, 8'h09);
    wr(8'h04, 8'h03);
    rd(8'h04, 8'h09);
    for (int c = 9; c >= 7; c--) begin
      wr(8'h0a, 8'(c));
      wl();
      wl();
      t = cyc;
      bl();
      chk(12'(n), 12'h028);
      wl();
      chk(12'(cyc - t), 12'(64 << (9 - c)));
    end
    wr(8'h16, 8'h01);
    rd(8'h16, 8'h01);
    wl();
    s = ns;
    wl();
    t = cyc;
    bl();
    chk(12'(n), 12'h014);
    chk(12'(ns - s), 12'h001);
    // Trigger while idle in continuous mode must neither start nor shift the schedule
    s = ns;
    wr(8'h0f, 8'h00);
    idle(100);
    chk(12'(ns - s), 12'h000);
    wl();
    chk(12'(cyc - t), 12'h100);
    wr(8'h16, 8'h03);
    wr(8'h11, 8'h02);
    wr(8'h23, 8'h08);
    wl();
    wl();
    idle(45);
    chk(remote_result_o, 12'h030);
    chk(local_result_o, 12'h010);
    wr(8'h09, 8'h40);
    rd(8'h03, 8'h40);
    idle(100);
    s = ns;
    idle(300);
    chk(12'(ns - s), 12'h000);
    wr(8'h0f, 8'ha5);
    idle(300);
    chk(12'(ns - s), 12'h002);
    wr(8'h16, 8'h02);
    wr(8'h0f, 8'h00);
    idle(60);
    chk(12'(ns - s), 12'h003);
    wr(8'h16, 8'h03);
    wr(8'h22, 8'h03);
    lv <= 12'h0c8;
    wr(8'h0f, 8'h00);
    idle(60);
    chk({11'h0, alarm_o}, 12'h000);
    wr(8'h0f, 8'h00);
    idle(60);
    chk({11'h0, local_over_flag_o}, 12'h001);
    chk({11'h0, alarm_o}, 12'h001);
    chk({8'h0, local_over_flag_o, local_under_flag_o, remote_over_flag_o, remote_under_flag_o}, 12'h008);
    // Clear while the fault persists keeps the flag; after an in-limit result it goes
    @(posedge sys_clk_i);
    flags_clear_i <= 1'b1;
    @(posedge sys_clk_i);
    flags_clear_i <= 1'b0;
    idle(2);
    chk({11'h0, alarm_o}, 12'h001);
    lv <= 12'h010;
    wr(8'h0f, 8'h00);
    idle(60);
    @(posedge sys_clk_i);
    flags_clear_i <= 1'b1;
    @(posedge sys_clk_i);
    flags_clear_i <= 1'b0;
    idle(2);
    chk({11'h0, alarm_o}, 12'h000);
    wrap_up();
  end
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
